// ### rtl/mfr_regs.svh
// Register map, field positions and timing constants of the fractional multiply unit
// Behaviour
// - Rounding multiply: signed 16x16 fractional product, 32-bit, rounded, written to destination.
// - Rounding-multiply sources only accumulator upper words or the three input registers.
// - Product sign extended to accumulator width before rounding; stored only after rounding.
// - Rounding multiply into 16-bit register stores upper 16 bits of rounded result.
// - Mode rounding bit clear gives convergent rounding, set gives two's-complement rounding.
// - Rounding multiply into accumulator always stores a zero low word.
// - Rounding multiply may negate one operand, giving rounded negated product.
// - Rounding multiply takes 2 clock cycles, plus move cycles with parallel move.
// - Arithmetic destination must differ from parallel read destination; memory write allowed.
// - Dual parallel reads forbidden while execute-from-data-memory mode bit is set.
// - Every rounding-multiply form is one word and one instruction cycle plus any parallel move cycles.
// - Mixed multiply: first source signed, second unsigned, 32-bit fractional product.
// - Mixed multiply into 16-bit register stores upper 16 bits only; sign may be lost.
// - Mixed multiply ignores saturation control bit entirely.
// - Negative from result MSB, zero when result zero, overflow always cleared.
// - Extension-in-use flag set when accumulator extension holds significant bits.
// - Limit flag on result overflow; rounding multiply also on parallel move limiting.
// - Accumulator destination receives product sign extended into extension bits.
// - Mixed multiply is one word and 2 clock cycles, first signed, second unsigned.
`ifndef MFR_REGS_SVH
`define MFR_REGS_SVH

// Byte offsets
`define MFR_OFS_CTRL      8'h00
`define MFR_OFS_MODE      8'h04
`define MFR_OFS_X0        8'h08
`define MFR_OFS_Y0        8'h0c
`define MFR_OFS_Y1        8'h10
`define MFR_OFS_ALO       8'h14
`define MFR_OFS_AEXT      8'h18
`define MFR_OFS_BLO       8'h1c
`define MFR_OFS_BEXT      8'h20
`define MFR_OFS_CCR       8'h24
`define MFR_OFS_STAT      8'h28

// Control word fields
`define MFR_C_START       0
`define MFR_C_MIXED       1
`define MFR_C_NEG         2
`define MFR_C_S1          5:3
`define MFR_C_S2          8:6
`define MFR_C_DST         11:9
`define MFR_C_PMOVE       12
`define MFR_C_DUAL        13
`define MFR_C_RDDST       16:14
`define MFR_C_PREAD       17
`define MFR_C_MVCYC       20:18
`define MFR_C_LIMIT       21
`define MFR_C_W           22

// Mode word fields
`define MFR_M_ROUND       0
`define MFR_M_XP          1
`define MFR_M_SAT         2
`define MFR_M_W           3

// Condition code fields
`define MFR_F_V           1
`define MFR_F_Z           2
`define MFR_F_N           3
`define MFR_F_U           4
`define MFR_F_E           5
`define MFR_F_L           6
`define MFR_F_W           7

// Status fields
`define MFR_S_BUSY        0
`define MFR_S_ERR         1

// Register selector codes
`define MFR_SEL_X0        3'h0
`define MFR_SEL_Y0        3'h1
`define MFR_SEL_Y1        3'h2
`define MFR_SEL_A         3'h3
`define MFR_SEL_B         3'h4
`define MFR_SEL_LAST      3'h4

// Datapath constants
`define MFR_RND_HALF      36'h0_0000_8000
`define MFR_LOW_HALF      16'h8000
`define MFR_CYC_PER_INSTR 2

`endif

// ### rtl/mfr_pkg.sv
// Types shared by the fractional multiply unit
package mfr_pkg;
  typedef enum logic [1:0] {
    MFR_IDLE = 2'b01,
    MFR_EXEC = 2'b10
  } mfr_state_t;

  typedef logic [35:0] mfr_acc_t;
  typedef logic [15:0] mfr_word_t;
endpackage : mfr_pkg

// ### rtl/mfr_mul_if.sv
// Operand and result bundle between controller and multiply datapath
`timescale 1ns/1ps
`include "mfr_regs.svh"
interface mfr_mul_if;
  logic              [15:0] srcA;
  logic              [15:0] srcB;
  logic                     mixed;
  logic                     negate;
  logic                     twosRound;
  logic                     destAcc;
  mfr_pkg::mfr_acc_t        accResult;
  mfr_pkg::mfr_word_t       wordResult;
  logic              [`MFR_F_W-1:0] flags;

  modport ctrl (output srcA, srcB, mixed, negate, twosRound, destAcc,
                input accResult, wordResult, flags);
  modport dp   (input srcA, srcB, mixed, negate, twosRound, destAcc,
                output accResult, wordResult, flags);
endinterface : mfr_mul_if

// ### rtl/mfr_mul_dp.sv
// Combinational multiply, negate, round and flag datapath
`timescale 1ns/1ps
`include "mfr_regs.svh"
module mfr_mul_dp (
  // Operands and results
  mfr_mul_if.dp mul
);
  logic signed [16:0] srcBx;
  logic signed [33:0] rawProd;
  mfr_pkg::mfr_acc_t  fracProd;
  mfr_pkg::mfr_acc_t  signedProd;
  mfr_pkg::mfr_acc_t  roundSum;
  mfr_pkg::mfr_acc_t  rounded;
  mfr_pkg::mfr_acc_t  res;
  logic               tieCase;

  // Second source zero extended for the mixed-sign form
  assign srcBx      = mul.mixed ? $signed({1'b0, mul.srcB})
                                : $signed({mul.srcB[15], mul.srcB});
  assign rawProd    = $signed(mul.srcA) * srcBx;
  // Fraction alignment, then sign extension to 36 bits
  assign fracProd   = {rawProd[33], rawProd[33], rawProd[32:0], 1'b0};
  // Negating the product avoids the 16-bit overflow of negating -1.0
  assign signedProd = (mul.negate && !mul.mixed) ? (36'h0 - fracProd) : fracProd;
  assign roundSum   = signedProd + `MFR_RND_HALF;
  assign tieCase    = !mul.twosRound && (signedProd[15:0] == `MFR_LOW_HALF);
  // Tie rounds to even: bit 16 forced low, low word always cleared
  assign rounded    = {roundSum[35:17], roundSum[16] & ~tieCase, 16'h0000};
  // Mixed form bypasses rounding; no form here applies saturation
  assign res        = mul.mixed ? signedProd : rounded;

  assign mul.accResult  = res;
  assign mul.wordResult = res[31:16];

  // Flags for the width actually written
  assign mul.flags[0]          = 1'b0;
  assign mul.flags[`MFR_F_V]   = 1'b0;
  assign mul.flags[`MFR_F_Z]   = mul.destAcc ? (res == 36'h0) : (res[31:16] == 16'h0000);
  assign mul.flags[`MFR_F_N]   = mul.destAcc ? res[35] : res[31];
  assign mul.flags[`MFR_F_U]   = ~(res[31] ^ res[30]);
  assign mul.flags[`MFR_F_E]   = mul.destAcc && (res[35:31] != {5{res[31]}});
  // Word target overflows when the extension held significant bits
  assign mul.flags[`MFR_F_L]   = !mul.destAcc && (res[35:31] != {5{res[31]}});
endmodule : mfr_mul_dp

// ### rtl/mfr_unit.sv
// Fractional multiply and round unit with AHB-Lite register slave
//
// Chosen here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "mfr_regs.svh"
module mfr_unit #(
  parameter int CYC_PER_INSTR = `MFR_CYC_PER_INSTR,
  parameter int CNT_W         = 4
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp
);
  // Counter must hold the longest busy span
  if (CYC_PER_INSTR < 1 || (CYC_PER_INSTR + 7) >= (1 << CNT_W))
  begin : g_chk
    $error("mfr_unit: CYC_PER_INSTR or CNT_W out of range");
  end

  mfr_mul_if mul ();

  mfr_mul_dp u_dp (
    .mul (mul.dp)
  );

  // Bus pipeline state
  logic [7:0]             addrReg;
  logic                   wrPendReg;
  logic                   rdPendReg;
  logic [31:0]            hrdataReg;
  logic                   hreadyoutReg;
  // Software visible state
  logic [`MFR_C_W-1:0]    ctrlReg;
  logic [`MFR_M_W-1:0]    modeReg;
  logic [15:0]            x0Reg, y0Reg, y1Reg;
  mfr_pkg::mfr_acc_t      accAReg, accBReg;
  logic [`MFR_F_W-1:0]    ccrReg;
  logic                   errReg;
  logic                   startReqReg;
  // Sequencer
  mfr_pkg::mfr_state_t    stateReg, stateNext;
  logic [CNT_W-1:0]       cntReg, cntNext;

  // Address phase accept and data phase write decode
  logic        accept;
  logic        wordOk;
  logic        busWr;
  logic        idle;
  logic        wrCtrl, wrMode, wrX0, wrY0, wrY1, wrALo, wrAExt, wrBLo, wrBExt, wrCcr, wrStat;
  assign accept = hsel && htrans[1] && hready;
  assign wordOk = (hsize == 3'h2) && (haddr[31:8] == 24'h000000);
  assign idle   = (stateReg == mfr_pkg::MFR_IDLE);
  assign busWr  = wrPendReg;
  // Operand and control writes are dropped while a multiply runs
  assign wrCtrl = busWr && idle && (addrReg == `MFR_OFS_CTRL);
  assign wrMode = busWr && idle && (addrReg == `MFR_OFS_MODE);
  assign wrX0   = busWr && idle && (addrReg == `MFR_OFS_X0);
  assign wrY0   = busWr && idle && (addrReg == `MFR_OFS_Y0);
  assign wrY1   = busWr && idle && (addrReg == `MFR_OFS_Y1);
  assign wrALo  = busWr && idle && (addrReg == `MFR_OFS_ALO);
  assign wrAExt = busWr && idle && (addrReg == `MFR_OFS_AEXT);
  assign wrBLo  = busWr && idle && (addrReg == `MFR_OFS_BLO);
  assign wrBExt = busWr && idle && (addrReg == `MFR_OFS_BEXT);
  assign wrCcr  = busWr && (addrReg == `MFR_OFS_CCR);
  assign wrStat = busWr && (addrReg == `MFR_OFS_STAT);

  // Read mux, unmapped offsets read as zero
  logic [31:0] rdMux;
  assign rdMux =
    (addrReg == `MFR_OFS_CTRL) ? {{(32-`MFR_C_W){1'b0}}, ctrlReg} :
    (addrReg == `MFR_OFS_MODE) ? {{(32-`MFR_M_W){1'b0}}, modeReg} :
    (addrReg == `MFR_OFS_X0)   ? {16'h0000, x0Reg} :
    (addrReg == `MFR_OFS_Y0)   ? {16'h0000, y0Reg} :
    (addrReg == `MFR_OFS_Y1)   ? {16'h0000, y1Reg} :
    (addrReg == `MFR_OFS_ALO)  ? accAReg[31:0] :
    (addrReg == `MFR_OFS_AEXT) ? {28'h0000000, accAReg[35:32]} :
    (addrReg == `MFR_OFS_BLO)  ? accBReg[31:0] :
    (addrReg == `MFR_OFS_BEXT) ? {28'h0000000, accBReg[35:32]} :
    (addrReg == `MFR_OFS_CCR)  ? {{(32-`MFR_F_W){1'b0}}, ccrReg} :
    (addrReg == `MFR_OFS_STAT) ? {30'h0, errReg, !idle} :
    32'h00000000;

  // Bus pipeline; one wait state on reads so a prior write is always visible
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      addrReg      <= 8'h00;
      wrPendReg    <= 1'b0;
      rdPendReg    <= 1'b0;
      hrdataReg    <= 32'h00000000;
      hreadyoutReg <= 1'b1;
    end
    else
    begin
      wrPendReg <= accept && hwrite && wordOk;
      rdPendReg <= accept && !hwrite;
      if (accept)
        addrReg <= wordOk ? haddr[7:0] : 8'hff;
      if (accept && !hwrite)
        hreadyoutReg <= 1'b0;
      else if (rdPendReg)
        hreadyoutReg <= 1'b1;
      if (rdPendReg)
        hrdataReg <= rdMux;
    end
  end

  assign hrdata    = hrdataReg;
  assign hreadyout = hreadyoutReg;
  assign hresp     = 1'b0;

  // Legality of the requested form, checked the cycle after the start write
  logic [2:0] s1Sel, s2Sel, dstSel, rdDstSel;
  logic       badSrc, badDest, badDual, badMove, badMixed, illegal, launch;
  assign s1Sel    = ctrlReg[`MFR_C_S1];
  assign s2Sel    = ctrlReg[`MFR_C_S2];
  assign dstSel   = ctrlReg[`MFR_C_DST];
  assign rdDstSel = ctrlReg[`MFR_C_RDDST];
  assign badSrc   = (s1Sel > `MFR_SEL_LAST) || (s2Sel > `MFR_SEL_LAST);
  assign badDest  = (dstSel > `MFR_SEL_LAST);
  assign badDual  = ctrlReg[`MFR_C_DUAL] && modeReg[`MFR_M_XP];
  // Memory writes may share the destination; only reads collide
  assign badMove  = ctrlReg[`MFR_C_PMOVE] && ctrlReg[`MFR_C_PREAD]
                    && (rdDstSel == dstSel);
  assign badMixed = ctrlReg[`MFR_C_MIXED] && (ctrlReg[`MFR_C_PMOVE] || ctrlReg[`MFR_C_DUAL]
                    || ctrlReg[`MFR_C_NEG]);
  assign illegal  = badSrc || badDest || badDual || badMove || badMixed;
  assign launch   = startReqReg && idle && !illegal;

  // Operand selection shared by both sources
  function automatic logic [15:0] pick(input logic [2:0] sel, input logic [15:0] a,
                                       input logic [15:0] b, input logic [15:0] c,
                                       input logic [15:0] d, input logic [15:0] e);
    pick = (sel == `MFR_SEL_X0) ? a :
           (sel == `MFR_SEL_Y0) ? b :
           (sel == `MFR_SEL_Y1) ? c :
           (sel == `MFR_SEL_A)  ? d : e;
  endfunction : pick

  // Datapath steering from the latched control and mode words
  assign mul.srcA      = pick(s1Sel, x0Reg, y0Reg, y1Reg, accAReg[31:16], accBReg[31:16]);
  assign mul.srcB      = pick(s2Sel, x0Reg, y0Reg, y1Reg, accAReg[31:16], accBReg[31:16]);
  assign mul.mixed     = ctrlReg[`MFR_C_MIXED];
  assign mul.negate    = ctrlReg[`MFR_C_NEG];
  assign mul.twosRound = modeReg[`MFR_M_ROUND];
  assign mul.destAcc   = (dstSel == `MFR_SEL_A) || (dstSel == `MFR_SEL_B);

  // Busy span is one instruction cycle plus any parallel move cycles
  logic [CNT_W-1:0] loadCnt;
  logic             finish;
  assign loadCnt = CNT_W'(CYC_PER_INSTR - 1)
                   + (ctrlReg[`MFR_C_PMOVE] ? CNT_W'(ctrlReg[`MFR_C_MVCYC]) : CNT_W'(0));
  assign finish  = (stateReg == mfr_pkg::MFR_EXEC) && (cntReg == '0);

  // Sequencer next state
  always_comb
  begin
    stateNext = stateReg;
    cntNext   = cntReg;
    case (stateReg)
      mfr_pkg::MFR_IDLE:
      begin
        if (launch)
        begin
          stateNext = mfr_pkg::MFR_EXEC;
          cntNext   = loadCnt;
        end
      end
      mfr_pkg::MFR_EXEC:
      begin
        if (cntReg == '0)
          stateNext = mfr_pkg::MFR_IDLE;
        else
          cntNext = cntReg - CNT_W'(1);
      end
      default:
      begin
        stateNext = mfr_pkg::MFR_IDLE;
        cntNext   = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stateReg <= mfr_pkg::MFR_IDLE;
      cntReg   <= '0;
    end
    else
    begin
      stateReg <= stateNext;
      cntReg   <= cntNext;
    end
  end

  // Write-back decode at the last busy cycle
  logic wbA, wbB, wbX0, wbY0, wbY1;
  assign wbA  = finish && (dstSel == `MFR_SEL_A);
  assign wbB  = finish && (dstSel == `MFR_SEL_B);
  assign wbX0 = finish && (dstSel == `MFR_SEL_X0);
  assign wbY0 = finish && (dstSel == `MFR_SEL_Y0);
  assign wbY1 = finish && (dstSel == `MFR_SEL_Y1);

  // Register next values; result stored only once, after rounding
  mfr_pkg::mfr_acc_t accANext, accBNext;
  logic [15:0]       x0Next, y0Next, y1Next;
  assign x0Next   = wbX0 ? mul.wordResult : wrX0 ? hwdata[15:0] : x0Reg;
  assign y0Next   = wbY0 ? mul.wordResult : wrY0 ? hwdata[15:0] : y0Reg;
  assign y1Next   = wbY1 ? mul.wordResult : wrY1 ? hwdata[15:0] : y1Reg;
  assign accANext = wbA ? mul.accResult :
                    {wrAExt ? hwdata[3:0] : accAReg[35:32], wrALo ? hwdata : accAReg[31:0]};
  assign accBNext = wbB ? mul.accResult :
                    {wrBExt ? hwdata[3:0] : accBReg[35:32], wrBLo ? hwdata : accBReg[31:0]};

  // Flags: limit is sticky, a hardware set beats a software clear
  logic [`MFR_F_W-1:0] ccrNext;
  logic                limSet;
  assign limSet  = finish && (mul.flags[`MFR_F_L]
                   || (!mul.mixed && ctrlReg[`MFR_C_PMOVE] && ctrlReg[`MFR_C_LIMIT]));
  assign ccrNext = finish ? {ccrReg[`MFR_F_L] | limSet, mul.flags[`MFR_F_E:0]} :
                   wrCcr  ? {hwdata[`MFR_F_L], hwdata[`MFR_F_E:`MFR_F_Z], 1'b0, hwdata[0]} :
                   ccrReg;

  // Error sticky; write one clears, a new refusal in that cycle wins
  logic errNext;
  assign errNext = (startReqReg && idle && illegal)
                   || (errReg && !(wrStat && hwdata[`MFR_S_ERR]));

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrlReg     <= '0;
      modeReg     <= '0;
      startReqReg <= 1'b0;
      errReg      <= 1'b0;
      ccrReg      <= '0;
    end
    else
    begin
      if (wrCtrl)
        ctrlReg <= {hwdata[`MFR_C_W-1:1], 1'b0};
      if (wrMode)
        modeReg <= hwdata[`MFR_M_W-1:0];
      startReqReg <= wrCtrl && hwdata[`MFR_C_START];
      errReg      <= errNext;
      ccrReg      <= ccrNext;
    end
  end

  // Data registers
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      x0Reg   <= 16'h0000;
      y0Reg   <= 16'h0000;
      y1Reg   <= 16'h0000;
      accAReg <= 36'h0_0000_0000;
      accBReg <= 36'h0_0000_0000;
    end
    else
    begin
      x0Reg   <= x0Next;
      y0Reg   <= y0Next;
      y1Reg   <= y1Next;
      accAReg <= accANext;
      accBReg <= accBNext;
    end
  end

  // Helper: cycles spent in the busy state for the current multiply
  logic [CNT_W-1:0] spanReg;
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      spanReg <= '0;
    else if (launch)
      spanReg <= '0;
    else if (!idle)
      spanReg <= spanReg + CNT_W'(1);
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  localparam int LAUNCH_MAX = CYC_PER_INSTR + 7;

  a_busy_span: assert property (finish |->
    spanReg == CNT_W'(CYC_PER_INSTR - 1)
    + (ctrlReg[`MFR_C_PMOVE] ? CNT_W'(ctrlReg[`MFR_C_MVCYC]) : CNT_W'(0)))
    else $error("busy span differs from instruction plus move cycles");
  a_mixed_span: assert property ((launch && ctrlReg[`MFR_C_MIXED]) |=>
    !idle ##1 finish)
    else $error("mixed multiply not two cycles");
  a_acc_low_zero: assert property ((wbA && !mul.mixed) |=> accAReg[15:0] == 16'h0000)
    else $error("rounded accumulator low word not zero");
  a_word_store: assert property (wbY1 |=> y1Reg == $past(mul.accResult[31:16]))
    else $error("word destination not the upper result half");
  a_ovf_clear: assert property (finish |=> !ccrReg[`MFR_F_V])
    else $error("overflow flag not cleared");
  a_zero_flag: assert property (wbB |=> ccrReg[`MFR_F_Z] == (accBReg == 36'h0))
    else $error("zero flag disagrees with accumulator");
  a_neg_flag: assert property (wbA |=> ccrReg[`MFR_F_N] == accAReg[35])
    else $error("negative flag disagrees with accumulator sign");
  a_ext_flag: assert property (wbA |=>
    ccrReg[`MFR_F_E] == (accAReg[35:31] != {5{accAReg[31]}}))
    else $error("extension flag wrong");
  a_sign_ext: assert property (wbB |=> accBReg[35:32] == {4{accBReg[35]}}
    && (accBReg[34:32] == {3{accBReg[35]}}))
    else $error("accumulator extension not sign extended");
  a_dual_refuse: assert property ((startReqReg && idle && ctrlReg[`MFR_C_DUAL]
    && modeReg[`MFR_M_XP]) |=> idle && errReg)
    else $error("dual read accepted in data memory mode");
  a_move_clash: assert property ((startReqReg && idle && badMove) |-> ##1 idle [*2])
    else $error("colliding parallel read destination accepted");
  a_src_legal: assert property ((startReqReg && idle && badSrc) |=>
    idle && errReg)
    else $error("illegal source selector launched");
  a_limit_move: assert property ((finish && !mul.mixed && ctrlReg[`MFR_C_PMOVE]
    && ctrlReg[`MFR_C_LIMIT]) |=> ccrReg[`MFR_F_L])
    else $error("limit flag missing after limited move");
  a_launch_bound: assert property (launch |->
    ##[1:LAUNCH_MAX] finish)
    else $error("multiply did not finish in time");
  a_read_ready: assert property (rdPendReg |-> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

  c_round_acc: cover property (wbA && !mul.mixed);
  c_mixed_word: cover property (wbX0 && mul.mixed);
  c_move_span: cover property (finish && ctrlReg[`MFR_C_PMOVE] && ctrlReg[`MFR_C_MVCYC] != 3'h0);
  c_refused: cover property (startReqReg && idle && illegal);
endmodule : mfr_unit

// ### bench/mfr_host_model.sv
// Bus master model standing in for the decoder and register file side
`timescale 1ns/1ps
module mfr_host_model (
  // Clock
  input  wire logic        core_clk,
  // AHB-Lite master side
  output logic             hsel   = 1'b0,
  output logic [31:0]      haddr  = 32'h0000_0000,
  output logic [1:0]       htrans = 2'h0,
  output logic             hwrite = 1'b0,
  output logic [2:0]       hsize  = 3'h2,
  output logic [31:0]      hwdata = 32'h0000_0000,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  // One single word transfer; each phase held until hready is seen high
  task automatic xfer(input logic wr, input logic [31:0] adr, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge core_clk);
    hsel   <= 1'b1;
    haddr  <= adr;
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge core_clk);
    while (hready !== 1'b1)
      @(posedge core_clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge core_clk);
    while (hready !== 1'b1)
      @(posedge core_clk);
    rd = hrdata;
    // Released data lines invert so a stale value never passes
    hwdata <= ~wd;
  endtask : xfer
endmodule : mfr_host_model

// ### bench/test_mfr_unit.sv
// Self-checking bench for the fractional multiply and round unit
`timescale 1ns/1ps
`include "mfr_regs.svh"
module test_mfr_unit;
  logic        core_clk = 1'b0;
  logic        nrst     = 1'b0;
  wire  logic  hsel, hwrite, hreadyout, hresp;
  wire  logic [31:0] haddr, hwdata, hrdata;
  wire  logic [1:0]  htrans;
  wire  logic [2:0]  hsize;
  int          fail_count = 0;
  int          checked    = 0;
  int          cycles     = 0;
  logic [31:0] rv;

  mfr_unit mfr_unit_i (.core_clk(core_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  mfr_host_model mfr_host_model_i (.core_clk(core_clk), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata));

  // Clock and hang guard
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      fail_count++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    mfr_host_model_i.xfer(1'b1, {24'h000000, a}, d, rv);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    mfr_host_model_i.xfer(1'b0, {24'h000000, a}, 32'h0000_0000, rv);
    chk(rv, exp);
  endtask : rdc

  // Control word; mv packs bits 21:12 (limit, extra cycles, read, read dest, dual, move)
  function automatic logic [31:0] cw(input logic mx, input logic ng, input logic [2:0] s1,
                                     input logic [2:0] s2, input logic [2:0] d,
                                     input logic [9:0] mv);
    cw = {10'h000, mv, d, s2, s1, ng, mx, 1'b1};
  endfunction : cw

  // Start and poll busy under a bounded count; polling is the only legal wait
  task automatic go(input logic [31:0] c);
    int n;
    wr(`MFR_OFS_CTRL, c);
    n = 0;
    rv = 32'h0000_0001;
    while (rv[`MFR_S_BUSY] !== 1'b0 && n < 20)
    begin
      mfr_host_model_i.xfer(1'b0, {24'h000000, `MFR_OFS_STAT}, 32'h0000_0000, rv);
      n++;
    end
    chk(rv, 32'h0000_0000);
  endtask : go

  task automatic end_of_test;
    if (fail_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  // Main sequence
  initial
  begin
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    rdc(`MFR_OFS_MODE, 32'h0000_0000);
    rdc(`MFR_OFS_CCR, 32'h0000_0000);
    mfr_host_model_i.xfer(1'b0, 32'h0000_0100, 32'h0000_0000, rv);
    chk(rv, 32'h0000_0000);
    // Negated product, convergent default
    wr(`MFR_OFS_X0, 32'h0000_4000);
    wr(`MFR_OFS_Y1, 32'h0000_f456);
    go(cw(1'b0, 1'b1, `MFR_SEL_X0, `MFR_SEL_Y1, `MFR_SEL_A, 10'h000));
    rdc(`MFR_OFS_ALO, 32'h05d5_0000);
    rdc(`MFR_OFS_AEXT, 32'h0000_0000);
    rdc(`MFR_OFS_CCR, 32'h0000_0010);
    // Tie case: convergent keeps even, two's complement rounds up
    wr(`MFR_OFS_X0, 32'h0000_0001);
    wr(`MFR_OFS_Y0, 32'h0000_4000);
    go(cw(1'b0, 1'b0, `MFR_SEL_X0, `MFR_SEL_Y0, `MFR_SEL_B, 10'h000));
    rdc(`MFR_OFS_BLO, 32'h0000_0000);
    rdc(`MFR_OFS_CCR, 32'h0000_0014);
    wr(`MFR_OFS_MODE, 32'h0000_0001);
    go(cw(1'b0, 1'b0, `MFR_SEL_X0, `MFR_SEL_Y0, `MFR_SEL_A, 10'h000));
    rdc(`MFR_OFS_ALO, 32'h0001_0000);
    // Busy seen on the first poll, idle on the second: two cycles
    wr(`MFR_OFS_CTRL, cw(1'b0, 1'b0, `MFR_SEL_X0, `MFR_SEL_Y0, `MFR_SEL_Y1, 10'h000));
    rdc(`MFR_OFS_STAT, 32'h0000_0001);
    rdc(`MFR_OFS_STAT, 32'h0000_0000);
    rdc(`MFR_OFS_Y1, 32'h0000_0001);
    // Mixed sign with saturation on
    wr(`MFR_OFS_MODE, 32'h0000_0004);
    wr(`MFR_OFS_X0, 32'h0000_3456);
    wr(`MFR_OFS_Y0, 32'h0000_8000);
    go(cw(1'b1, 1'b0, `MFR_SEL_X0, `MFR_SEL_Y0, `MFR_SEL_A, 10'h000));
    rdc(`MFR_OFS_ALO, 32'h3456_0000);
    // Accumulator upper word as source, negative result
    go(cw(1'b0, 1'b0, `MFR_SEL_A, `MFR_SEL_Y0, `MFR_SEL_B, 10'h000));
    rdc(`MFR_OFS_BLO, 32'hcbaa_0000);
    rdc(`MFR_OFS_BEXT, 32'h0000_000f);
    rdc(`MFR_OFS_CCR, 32'h0000_0018);
    // Minus one squared gives +1.0 and sets the extension-in-use flag
    wr(`MFR_OFS_X0, 32'h0000_8000);
    go(cw(1'b0, 1'b0, `MFR_SEL_X0, `MFR_SEL_Y0, `MFR_SEL_A, 10'h000));
    rdc(`MFR_OFS_ALO, 32'h8000_0000);
    rdc(`MFR_OFS_CCR, 32'h0000_0020);
    go(cw(1'b1, 1'b0, `MFR_SEL_X0, `MFR_SEL_Y0, `MFR_SEL_Y1, 10'h000));
    rdc(`MFR_OFS_Y1, 32'h0000_8000);
    // Parallel move of 7 extra cycles with limited data; writes while busy drop
    wr(`MFR_OFS_CTRL, cw(1'b0, 1'b0, `MFR_SEL_X0, `MFR_SEL_Y0, `MFR_SEL_A, 10'h3c1));
    wr(`MFR_OFS_X0, 32'h0000_1234);
    rdc(`MFR_OFS_STAT, 32'h0000_0001);
    go(cw(1'b0, 1'b0, `MFR_SEL_X0, `MFR_SEL_Y0, `MFR_SEL_A, 10'h000));
    rdc(`MFR_OFS_X0, 32'h0000_8000);
    rdc(`MFR_OFS_CCR, 32'h0000_0060);
    // Dual read refused while executing from data memory
    wr(`MFR_OFS_MODE, 32'h0000_0002);
    wr(`MFR_OFS_CTRL, cw(1'b0, 1'b0, `MFR_SEL_X0, `MFR_SEL_Y0, `MFR_SEL_A, 10'h002));
    rdc(`MFR_OFS_STAT, 32'h0000_0002);
    wr(`MFR_OFS_STAT, 32'h0000_0002);
    wr(`MFR_OFS_MODE, 32'h0000_0000);
    // Parallel read into the arithmetic destination refused, memory write allowed
    wr(`MFR_OFS_CTRL, cw(1'b0, 1'b0, `MFR_SEL_X0, `MFR_SEL_Y0, `MFR_SEL_A, 10'h02d));
    rdc(`MFR_OFS_STAT, 32'h0000_0002);
    wr(`MFR_OFS_STAT, 32'h0000_0002);
    go(cw(1'b0, 1'b0, `MFR_SEL_X0, `MFR_SEL_Y0, `MFR_SEL_A, 10'h00d));
    // Source selector outside the legal set refused
    wr(`MFR_OFS_CTRL, cw(1'b0, 1'b0, 3'h5, `MFR_SEL_Y0, `MFR_SEL_A, 10'h000));
    rdc(`MFR_OFS_STAT, 32'h0000_0002);
    wr(`MFR_OFS_STAT, 32'h0000_0002);
    rdc(`MFR_OFS_STAT, 32'h0000_0000);
    chk({31'h00000000, hresp}, 32'h0000_0000);
    end_of_test();
  end
endmodule : test_mfr_unit
